// ---- hdl/spi_serial_eeprom_slave.sv ----
// Serial memory slave: link framing, commands, protection, timed writes.
`timescale 1ns/10ps
module spi_serial_eeprom_slave #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
    parameter int DEPTH        = eeprom_pkg::MEM_DEPTH
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic select_n_i,
    input  wire logic sclk_i,
    input  wire logic sdi_i,
    input  wire logic pause_n_i,
    input  wire logic protect_n_i,
    output logic      sdo_o,
    output logic      sdo_oe_o,
    output logic      busy_o
);
    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int PB = eeprom_pkg::PAGE_BITS;
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    typedef enum logic [2:0] {
        S_IDLE, S_OPCODE, S_ADDR, S_DATA, S_STAT_IN, S_READ, S_DEAD
    } phase_t;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic       sclk_d1_q;
    logic       prot_d1_q;
    logic       sel_d1_q;
    logic       sel, sclk, sdi, pause_n, prot_n;
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            meta_q    <= 5'h1D;
            sync_q    <= 5'h1D;
            sclk_d1_q <= 1'b0;
            prot_d1_q <= 1'b1;
            sel_d1_q  <= 1'b0;
        end
        else
        begin
            meta_q    <= {protect_n_i, pause_n_i, sdi_i, sclk_i, select_n_i};
            sync_q    <= meta_q;
            sclk_d1_q <= sclk;
            prot_d1_q <= prot_n;
            sel_d1_q  <= sel;
        end
    end
    assign sel     = ~sync_q[0];
    assign sclk    = sync_q[1];
    assign sdi     = sync_q[2];
    assign pause_n = sync_q[3];
    assign prot_n  = sync_q[4];

    logic sel_fall, rise, fall, prot_fall;
    assign sel_fall  = sel && !sel_d1_q;
    // Edges count only while selected and not paused.
    assign rise      = sel && pause_n && sclk && !sclk_d1_q;
    assign fall      = sel && pause_n && !sclk && sclk_d1_q;
    assign prot_fall = !prot_n && prot_d1_q;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    phase_t             phase_q;
    logic [7:0]         shift_q;
    logic [3:0]         bits_q;
    logic [15:0]        addr_q;
    logic [7:0]         opcode_q;
    logic [7:0]         out_q;
    logic               oe_q;
    logic               wel_q;
    logic [1:0]         bp_q;
    logic               ppe_q;
    logic               stat_ok_q;
    logic [7:0]         stat_new_q;
    logic               stat_pend_q;
    logic [CW-1:0]      timer_q;
    logic               wr_busy_q;
    logic               is_stat_q;
    logic [7:0]         mem_q [DEPTH];

    logic [7:0] status;
    logic       hw_locked;
    logic [7:0] next_byte;
    logic       byte_done;
    assign next_byte = {shift_q[6:0], sdi};
    assign byte_done = rise && (bits_q == 4'h7);
    // Pin only counts when the enable bit is set.
    assign hw_locked = ppe_q && !prot_n;
    assign status = wr_busy_q ? eeprom_pkg::STATUS_BUSY_V :
        {ppe_q, 3'h0, bp_q, wel_q, 1'b0};

    function automatic logic is_prot(input logic [AW-1:0] a,
                                     input logic [1:0] bp);
        case (bp)
            eeprom_pkg::LVL_QUARTER: is_prot = a >= eeprom_pkg::PROT_QUARTER;
            eeprom_pkg::LVL_HALF:    is_prot = a >= eeprom_pkg::PROT_HALF;
            eeprom_pkg::LVL_ALL:     is_prot = 1'b1;
            default:                 is_prot = 1'b0;
        endcase
    endfunction

    // Page bytes wait in the FIFO until select rises.
    byte_stream_if #(.WIDTH(AW + 8)) wr_in ();
    byte_stream_if #(.WIDTH(AW + 8)) wr_out ();
    stream_fifo #(
        .WIDTH (AW + 8),
        .DEPTH (eeprom_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .in_s       (wr_in),
        .out_s      (wr_out)
    );
    logic commit_q;
    // Without the write latch no byte is queued, so none can linger.
    assign wr_in.valid = byte_done && phase_q == S_DATA && wel_q;
    assign wr_in.data  = {addr_q[AW-1:0], next_byte};
    assign wr_out.ready = commit_q;

    // ------------------------------------------------------------------
    // Serial sequence
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !sel)
        begin
            // Deselect drops input and floats the output.
            phase_q <= S_IDLE;
            bits_q  <= '0;
            oe_q    <= 1'b0;
        end
        else if (sel_fall)
        begin
            phase_q <= S_OPCODE;
            bits_q  <= '0;
        end
        else
        begin
            if (rise && phase_q != S_DEAD && phase_q != S_READ)
            begin
                shift_q <= next_byte;
                bits_q  <= byte_done ? 4'h0 : bits_q + 4'h1;
            end
            if (fall && phase_q == S_READ)
            begin
                // The first fall of each byte shows its top bit.
                out_q <= (bits_q == 4'h0) ? (is_stat_q ? status :
                         mem_q[AW'(addr_q)]) : {out_q[6:0], 1'b0};
                bits_q <= (bits_q == 4'h7) ? 4'h0 : bits_q + 4'h1;
                if (bits_q == 4'h7)
                    addr_q <= addr_q + 16'h1;
                oe_q <= 1'b1;
            end
            if (byte_done)
            begin
                case (phase_q)
                    S_OPCODE:
                    begin
                        opcode_q  <= {next_byte[7:4], 1'b0, next_byte[2:0]};
                        is_stat_q <= 1'b0;
                        if (next_byte[7:4] != eeprom_pkg::OP_HIGH_ZERO)
                            phase_q <= S_DEAD;
                        else if (wr_busy_q &&
                                 next_byte[2:0] != eeprom_pkg::OP_READ_STAT)
                            phase_q <= S_DEAD;
                        else
                            case (next_byte[2:0])
                                eeprom_pkg::OP_SET_LATCH,
                                eeprom_pkg::OP_CLR_LATCH: phase_q <= S_DEAD;
                                eeprom_pkg::OP_READ_STAT:
                                begin
                                    phase_q   <= S_READ;
                                    is_stat_q <= 1'b1;
                                    out_q     <= status;
                                end
                                eeprom_pkg::OP_WRITE_STAT:
                                    phase_q <= S_STAT_IN;
                                eeprom_pkg::OP_READ_ARRAY,
                                eeprom_pkg::OP_WRITE_ARRAY:
                                    phase_q <= S_ADDR;
                                default: phase_q <= S_DEAD;
                            endcase
                    end
                    S_ADDR:
                    begin
                        addr_q <= {addr_q[7:0], next_byte};
                        if (opcode_q[3])
                        begin
                            if (opcode_q[2:0] ==
                                eeprom_pkg::OP_READ_ARRAY)
                            begin
                                phase_q <= S_READ;
                                out_q   <= mem_q[AW'({addr_q[7:0],
                                                      next_byte})];
                            end
                            else
                                phase_q <= S_DATA;
                        end
                        opcode_q[3] <= 1'b1;
                    end
                    S_DATA:
                        // Only the low page bits advance.
                        addr_q[PB-1:0] <= addr_q[PB-1:0] + PB'(1);
                    S_STAT_IN:
                        phase_q <= S_DEAD;
                    default: phase_q <= phase_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Status write arming
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || sel_fall)
        begin
            stat_ok_q  <= 1'b0;
            stat_new_q <= '0;
        end
        else if (byte_done && phase_q == S_STAT_IN)
        begin
            stat_ok_q  <= wel_q && !hw_locked;
            stat_new_q <= next_byte;
        end
        else if (sel && prot_fall && ppe_q)
            stat_ok_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Write latch, status bits and timed write cycle
    // ------------------------------------------------------------------
    logic sel_rise;
    logic arr_commit;
    assign sel_rise   = !sel && sel_d1_q;
    assign arr_commit = sel_rise && wr_out.valid && wel_q && !wr_busy_q;
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            wel_q       <= 1'b0;
            bp_q        <= '0;
            ppe_q       <= 1'b0;
            wr_busy_q   <= 1'b0;
            timer_q     <= '0;
            commit_q    <= 1'b0;
            stat_pend_q <= 1'b0;
        end
        else
        begin
            if (byte_done && phase_q == S_OPCODE && !wr_busy_q &&
                next_byte[7:4] == eeprom_pkg::OP_HIGH_ZERO)
            begin
                if (next_byte[2:0] == eeprom_pkg::OP_SET_LATCH)
                    wel_q <= 1'b1;
                else if (next_byte[2:0] == eeprom_pkg::OP_CLR_LATCH)
                    wel_q <= 1'b0;
            end
            if (sel_rise && stat_ok_q && !wr_busy_q)
            begin
                // Once started the pin no longer matters.
                stat_pend_q <= 1'b1;
                wr_busy_q   <= 1'b1;
                timer_q     <= CW'(WRITE_CYCLES);
            end
            else if (arr_commit)
            begin
                commit_q  <= 1'b1;
                wr_busy_q <= 1'b1;
                timer_q   <= CW'(WRITE_CYCLES);
            end
            else if (wr_busy_q)
            begin
                // The timer runs while the queue drains, so the cycle
                // length does not depend on the number of bytes.
                if (commit_q && !wr_out.valid)
                    commit_q <= 1'b0;
                if (timer_q == '0 && !commit_q)
                begin
                    wr_busy_q   <= 1'b0;
                    wel_q       <= 1'b0;
                    stat_pend_q <= 1'b0;
                    if (stat_pend_q)
                    begin
                        bp_q  <= stat_new_q[eeprom_pkg::ST_BP_HI:
                                            eeprom_pkg::ST_BP_LO];
                        ppe_q <= stat_new_q[eeprom_pkg::ST_PPE];
                    end
                end
                else if (timer_q != '0)
                    timer_q <= timer_q - CW'(1);
            end
        end
    end

    // Queued page bytes land in storage, skipping protected addresses.
    always_ff @(posedge core_clk_i)
    begin
        if (commit_q && wr_out.valid &&
            !is_prot(wr_out.data[AW+7:8], bp_q))
            mem_q[wr_out.data[AW+7:8]] <= wr_out.data[7:0];
    end

    // The serial clock is only ever sampled, never driven.
    assign sdo_o    = out_q[7];
    assign sdo_oe_o = oe_q && pause_n && phase_q == S_READ;
    assign busy_o   = wr_busy_q;
endmodule

// ---- hdl/eeprom_pkg.sv ----
// Package of constants shared by the serial memory slave design.
package eeprom_pkg;
    localparam int          MEM_DEPTH      = 16384;
    localparam int          ADDR_W         = 14;
    localparam int          PAGE_BITS      = 5;
    localparam int          FIFO_DEPTH     = 8;
    localparam logic [3:0]  OP_HIGH_ZERO   = 4'h0;
    localparam logic [2:0]  OP_SET_LATCH   = 3'h6;
    localparam logic [2:0]  OP_CLR_LATCH   = 3'h4;
    localparam logic [2:0]  OP_READ_STAT   = 3'h5;
    localparam logic [2:0]  OP_WRITE_STAT  = 3'h1;
    localparam logic [2:0]  OP_READ_ARRAY  = 3'h3;
    localparam logic [2:0]  OP_WRITE_ARRAY = 3'h2;
    localparam int          ST_BUSY        = 0;
    localparam int          ST_WEL         = 1;
    localparam int          ST_BP_LO       = 2;
    localparam int          ST_BP_HI       = 3;
    localparam int          ST_PPE         = 7;
    localparam logic [7:0]  STATUS_BUSY_V  = 8'hFF;
    localparam logic [13:0] PROT_QUARTER   = 14'h3000;
    localparam logic [13:0] PROT_HALF      = 14'h2000;
    localparam int          WRITE_TIME_US  = 5000;
    localparam int          CLK_MHZ        = 50;
    localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        LVL_NONE,
        LVL_QUARTER,
        LVL_HALF,
        LVL_ALL
    } prot_level_t;
endpackage

// ---- hdl/byte_stream_if.sv ----
// Valid/ready byte stream carrier between the slave and its write FIFO.
`timescale 1ns/10ps
interface byte_stream_if #(parameter int WIDTH = 22);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// ---- hdl/stream_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module stream_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    byte_stream_if.sink   in_s,
    byte_stream_if.source out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge core_clk_i)
    begin
        if (push)
            mem_q[wr_q] <= in_s.data;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- sim/spi_serial_eeprom_slave_properties.sv ----
// Port-level property checker for the serial memory slave.
`timescale 1ns/10ps
module spi_serial_eeprom_slave_properties #(
    parameter int WRITE_CYCLES = 50
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic select_n_i,
    input  wire logic sclk_i,
    input  wire logic sdi_i,
    input  wire logic pause_n_i,
    input  wire logic protect_n_i,
    input  wire logic sdo_o,
    input  wire logic sdo_oe_o,
    input  wire logic busy_o
);
    // ------------------------------------------------------------------
    // Helper counters and properties
    // ------------------------------------------------------------------
    logic [31:0] busy_cnt_q;
    logic [7:0]  rise_cnt_q;
    logic        sclk_q;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    always_ff @(posedge core_clk_i)
    begin
        busy_cnt_q <= (sys_rst_i || !busy_o) ? 32'h0 : busy_cnt_q + 32'h1;
    end

    // Raw clock rises lead the design's synchronised view of them.
    always_ff @(posedge core_clk_i)
    begin
        sclk_q <= sclk_i;
        if (sys_rst_i || select_n_i)
            rise_cnt_q <= 8'h00;
        else if (sclk_i && !sclk_q && rise_cnt_q != 8'hFF)
            rise_cnt_q <= rise_cnt_q + 8'h01;
    end

    AST_DESELECT_HIZ: assert property ((select_n_i) [*5] |-> !sdo_oe_o)
        else $error("output driven while deselected");
    AST_OE_DROPS: assert property ($rose(select_n_i) |-> ##[1:5] !sdo_oe_o)
        else $error("output still driven after deselect");
    AST_PAUSE_HIZ: assert property ((!pause_n_i) [*5] |-> !sdo_oe_o)
        else $error("output driven while paused");
    AST_OE_AFTER_OPCODE: assert property ((!select_n_i) [*5] ##0 sdo_oe_o |-> rise_cnt_q >= 8'h08)
        else $error("output driven inside the opcode byte");
    AST_SDO_HOLDS_HIGH: assert property ((sclk_i && sdo_oe_o) [*3] |-> $stable(sdo_o))
        else $error("output changed during clock high phase");
    AST_BUSY_AFTER_DESELECT: assert property ($rose(busy_o) |-> select_n_i && $past(select_n_i))
        else $error("write cycle began while selected");
    AST_BUSY_LENGTH: assert property ($fell(busy_o) |-> busy_cnt_q == WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    AST_BUSY_CAP: assert property (busy_o |-> busy_cnt_q <= WRITE_CYCLES)
        else $error("write cycle overran");

    cover property ($rose(busy_o));
    cover property ($fell(pause_n_i) && !select_n_i);
    cover property ($fell(protect_n_i) && busy_o);
endmodule

bind spi_serial_eeprom_slave spi_serial_eeprom_slave_properties #(
    .WRITE_CYCLES(WRITE_CYCLES)
) i_spi_serial_eeprom_slave_properties (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .select_n_i(select_n_i),
    .sclk_i(sclk_i),
    .sdi_i(sdi_i),
    .pause_n_i(pause_n_i),
    .protect_n_i(protect_n_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .busy_o(busy_o)
);

// ---- sim/spi_host_model.sv ----
// Serial bus master model that drives the memory slave link.
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic core_clk_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      select_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      pause_n_o,
    output logic      protect_n_o
);
    // ------------------------------------------------------------------
    // Link driver
    // ------------------------------------------------------------------
    logic cpol_q = 1'b0;
    logic oe_seen_q = 1'b0;
    logic last_q = 1'b0;

    initial
    begin
        select_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        pause_n_o = 1'b1;
        protect_n_o = 1'b1;
    end

    // A released data line shows a changing pattern, not a held level.
    always @(posedge core_clk_i)
    begin
        if (select_n_o)
            sdi_o <= ~sdi_o;
        if (sdo_oe_i)
            oe_seen_q <= 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic set_mode(input logic m);
        cpol_q <= m;
        sclk_o <= m;
        tick(8);
    endtask

    task automatic open_frame();
        oe_seen_q  <= 1'b0;
        select_n_o <= 1'b0;
        tick(8);
    endtask

    task automatic close_frame();
        tick(4);
        sclk_o <= cpol_q;
        tick(4);
        select_n_o <= 1'b1;
        tick(16);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic hold,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sclk_o <= 1'b0;
            sdi_o  <= tx[i];
            tick(4);
            if (hold && i == 3)
            begin
                pause_n_o <= 1'b0;
                tick(2);
                sclk_o <= 1'b1;
                sdi_o  <= ~tx[i];
                tick(4);
                sclk_o <= 1'b0;
                tick(4);
                pause_n_o <= 1'b1;
                sdi_o  <= tx[i];
                tick(4);
            end
            sclk_o <= 1'b1;
            tick(4);
            rx[i]  = sdo_oe_i ? sdo_i : ~last_q;
            last_q = rx[i];
        end
    endtask
endmodule

// ---- sim/spi_serial_eeprom_slave_tb.sv ----
// Self-checking testbench for the serial memory slave.
`timescale 1ns/10ps
module spi_serial_eeprom_slave_tb;
    // ------------------------------------------------------------------
    // Bench, access tasks and tests
    // ------------------------------------------------------------------
    localparam int WCYC = 800;
    logic       core_clk_i, sys_rst_i, sel_n, sclk, sdi, pause_n, prot_n;
    logic       sdo, sdo_oe, busy;
    logic [7:0] rxb [6];
    logic [7:0] mem_e [3];
    logic [15:0] probe [3] = '{16'h3000, 16'h2000, 16'h0000};
    int         errors = 0, check_count = 0, cycles = 0;

    spi_serial_eeprom_slave #(.WRITE_CYCLES(WCYC)) i_spi_serial_eeprom_slave (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .select_n_i(sel_n),
        .sclk_i(sclk), .sdi_i(sdi), .pause_n_i(pause_n),
        .protect_n_i(prot_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .busy_o(busy));
    spi_host_model i_spi_host_model (
        .core_clk_i(core_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .select_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi),
        .pause_n_o(pause_n), .protect_n_o(prot_n));

    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            errors++;
            $display("[ERR] %0t run time limit reached", $time);
            report_and_stop();
        end
    end

    function automatic logic [7:0] op(input logic [2:0] c);
        return {eeprom_pkg::OP_HIGH_ZERO, 1'b0, c};
    endfunction

    function automatic logic guarded(input int lvl, input logic [15:0] a);
        return lvl == 3 || (lvl == 2 && a[13:0] >= eeprom_pkg::PROT_HALF)
            || (lvl == 1 && a[13:0] >= eeprom_pkg::PROT_QUARTER);
    endfunction

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [7:0] b [6], input int n,
                         input logic hold);
        i_spi_host_model.open_frame();
        for (int i = 0; i < n; i++)
            i_spi_host_model.xfer(b[i], hold && i == n - 1, rxb[i]);
        i_spi_host_model.close_frame();
    endtask

    task automatic cmd(input logic [7:0] c);
        frame('{c, 0, 0, 0, 0, 0}, 1, 1'b0);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 1000 && busy !== 1'b0; n++)
            @(posedge core_clk_i);
    endtask

    task automatic rd_stat(input logic [7:0] exp, input logic [7:0] c = 8'h05);
        frame('{c, 0, 0, 0, 0, 0}, 2, 1'b0);
        check_byte(rxb[1], exp);
    endtask

    task automatic rd_mem(input logic [15:0] a, input logic [7:0] exp);
        frame('{op(eeprom_pkg::OP_READ_ARRAY), a[15:8], a[7:0], 0, 0, 0},
              4, 1'b0);
        check_byte(rxb[3], exp);
    endtask

    task automatic wr_mem(input logic [15:0] a, input logic [7:0] d,
                          input logic hold);
        cmd(op(eeprom_pkg::OP_SET_LATCH));
        frame('{op(eeprom_pkg::OP_WRITE_ARRAY), a[15:8], a[7:0], d, 0, 0},
              4, hold);
    endtask

    task automatic wr_stat(input logic [7:0] v);
        cmd(op(eeprom_pkg::OP_SET_LATCH));
        frame('{op(eeprom_pkg::OP_WRITE_STAT), v, 0, 0, 0, 0}, 2, 1'b0);
        wait_idle();
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        sys_rst_i = 1'b1;
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rd_stat(8'h00);
        cmd(op(eeprom_pkg::OP_SET_LATCH));
        rd_stat(8'h02);
        rd_stat(8'h02, 8'h0D);
        cmd(op(eeprom_pkg::OP_CLR_LATCH) | 8'h08);
        rd_stat(8'h00);
        $display("Test write latch done");
        wr_mem(16'h0010, 8'hA5, 1'b1);
        rd_stat(eeprom_pkg::STATUS_BUSY_V);
        frame('{op(eeprom_pkg::OP_READ_ARRAY), 0, 8'h10, 0, 0, 0}, 4, 1'b0);
        check_byte({7'h00, i_spi_host_model.oe_seen_q}, 8'h00);
        wait_idle();
        rd_stat(8'h00);
        i_spi_host_model.set_mode(1'b1);
        rd_mem(16'hC010, 8'hA5);
        i_spi_host_model.set_mode(1'b0);
        $display("Test write and read done");
        cmd(op(eeprom_pkg::OP_SET_LATCH));
        frame('{op(eeprom_pkg::OP_WRITE_ARRAY), 0, 8'h3E, 8'h11, 8'h22, 8'h33},
              6, 1'b0);
        wait_idle();
        rd_mem(16'h003E, 8'h11);
        frame('{op(eeprom_pkg::OP_READ_ARRAY), 0, 8'h3F, 0, 0, 0}, 4, 1'b1);
        check_byte(rxb[3], 8'h22);
        rd_mem(16'h0020, 8'h33);
        frame('{op(eeprom_pkg::OP_WRITE_ARRAY), 0, 8'h3E, 8'h77, 0, 0},
              4, 1'b0);
        wait_idle();
        rd_mem(16'h003E, 8'h11);
        $display("Test page wrap done");
        for (int lvl = 0; lvl < 4; lvl++)
        begin
            wr_stat(8'(lvl << 2));
            rd_stat(8'(lvl << 2));
            for (int k = 0; k < 3; k++)
            begin
                wr_mem(probe[k], 8'h40 + 8'(lvl), 1'b0);
                wait_idle();
                if (!guarded(lvl, probe[k]))
                    mem_e[k] = 8'h40 + 8'(lvl);
                rd_mem(probe[k], mem_e[k]);
            end
        end
        wr_stat(8'h00);
        rd_mem(16'h003E, 8'h11);
        $display("Test block protect done");
        wr_stat(8'h80);
        i_spi_host_model.protect_n_o <= 1'b0;
        wr_stat(8'h8C);
        cmd(op(eeprom_pkg::OP_CLR_LATCH));
        rd_stat(8'h80);
        i_spi_host_model.protect_n_o <= 1'b1;
        cmd(op(eeprom_pkg::OP_SET_LATCH));
        i_spi_host_model.open_frame();
        i_spi_host_model.xfer(op(eeprom_pkg::OP_WRITE_STAT), 1'b0, rxb[0]);
        i_spi_host_model.xfer(8'h8C, 1'b0, rxb[1]);
        i_spi_host_model.protect_n_o <= 1'b0;
        i_spi_host_model.tick(8);
        i_spi_host_model.close_frame();
        wait_idle();
        cmd(op(eeprom_pkg::OP_CLR_LATCH));
        rd_stat(8'h80);
        i_spi_host_model.protect_n_o <= 1'b1;
        cmd(op(eeprom_pkg::OP_SET_LATCH));
        frame('{op(eeprom_pkg::OP_WRITE_STAT), 8'h8C, 0, 0, 0, 0}, 2, 1'b0);
        i_spi_host_model.protect_n_o <= 1'b0;
        wait_idle();
        rd_stat(8'h8C);
        i_spi_host_model.protect_n_o <= 1'b1;
        wr_stat(8'h00);
        rd_stat(8'h00);
        i_spi_host_model.protect_n_o <= 1'b0;
        wr_stat(8'h04);
        rd_stat(8'h04);
        wr_stat(8'h00);
        $display("Test protect pin done");
        frame('{8'h07, op(eeprom_pkg::OP_READ_STAT), 0, 0, 0, 0}, 3, 1'b0);
        check_byte({7'h00, i_spi_host_model.oe_seen_q}, 8'h00);
        rd_stat(8'h00);
        $display("Test bad opcode done");
        report_and_stop();
    end
endmodule
